// *** core/wdt_top.sv ***
`timescale 1ns/100ps
module wdt_top #(
	parameter logic [31:0] SEC_CYC = 32'h05F5_E100,
	parameter logic [31:0] GAP_CYC = 32'h05F5_E100
) (
	input  wire logic                   mclk,
	input  wire logic                   srst,
	input  wire logic                   powerOnRst,
	input  wire logic [wdt_pkg::IO_AW-1:0] ioAddr,
	input  wire logic                   ioRd,
	input  wire logic                   ioWr,
	input  wire logic [7:0]             ioWrData,
	output logic      [7:0]             ioRdData,
	input  wire logic                   frontResetButton,
	output logic                        nonmaskableInterrupt,
	output logic                        processorSoftInit,
	output logic                        hardReset,
	output logic                        statusLed
);
	import wdt_pkg::*;

	wdt_state_t  state_r;
	wdt_state_t  state_nxt;
	logic [7:0]  term_r;
	logic [7:0]  count_r;
	logic        enable_r;
	logic        arm_r;
	logic        minutes_r;
	logic        selInit_r;
	logic        cause_r;
	logic [31:0] gap_r;
	logic [7:0]  rst_r;
	logic        hitStrobe;
	logic        hitCtrl;
	logic        strobe;
	logic        ctrlWr;
	logic        unitTick;
	logic        buttonLvl;
	logic        buttonRise;
	logic        expire;
	logic        gapDone;
	logic        anyRst;

	assign anyRst    = srst | powerOnRst;
	assign hitStrobe = (ioAddr == ADDR_STROBE);
	assign hitCtrl   = (ioAddr == ADDR_CTRL); // RULE12
	assign strobe    = hitStrobe && (ioRd || ioWr); // RULE5 RULE6
	assign ctrlWr    = hitCtrl && ioWr;

	wdt_timebase #(
		.SEC_CYC (SEC_CYC)
	) uTimebase (
		.mclk     (mclk),
		.srst     (anyRst),
		.restart  (strobe || state_r != ST_COUNT),
		.minutes  (minutes_r),
		.unitTick (unitTick)
	);

	wdt_sync uButton (
		.mclk      (mclk),
		.srst      (anyRst),
		.pinIn     (frontResetButton),
		.levelOut  (buttonLvl),
		.risePulse (buttonRise)
	);

	// Control bits; dropping enable or arm stops counting and the first stage at once, but not the second stage
	always_ff @(posedge mclk) begin
		if (anyRst) begin
			enable_r  <= CTL_RESET[CTL_ENABLE];
			arm_r     <= CTL_RESET[CTL_ARM];
			minutes_r <= CTL_RESET[CTL_MINUTES];
			selInit_r <= CTL_RESET[CTL_SEL_INIT];
		end else if (ctrlWr) begin
			enable_r  <= ioWrData[CTL_ENABLE]; // RULE8
			arm_r     <= ioWrData[CTL_ARM]; // RULE9
			minutes_r <= ioWrData[CTL_MINUTES]; // RULE1
			selInit_r <= ioWrData[CTL_SEL_INIT]; // RULE3
		end else if (state_r == ST_STAGE2) begin
			arm_r <= 1'b0;
		end
	end

	// Terminal count loads from strobe-port writes only while disarmed,
	// so a running strobe loop cannot alter the period by accident.
	always_ff @(posedge mclk) begin
		if (anyRst) begin
			term_r <= TERM_RESET;
		end else if (hitStrobe && ioWr && !arm_r && ioWrData != TERM_ZERO) begin
			term_r <= ioWrData; // RULE1
		end
	end

	// Cause flag: cleared only at power-up or by software, set wins
	always_ff @(posedge mclk) begin
		if (powerOnRst) begin
			cause_r <= 1'b0;
		end else if (state_r == ST_STAGE2) begin
			cause_r <= 1'b1; // RULE7 RULE15
		end else if (ctrlWr && ioWrData[CTL_CLR_CAUSE]) begin
			cause_r <= 1'b0;
		end
	end

	assign expire  = unitTick && (count_r + 8'h01 >= term_r);
	assign gapDone = (gap_r == GAP_CYC - 32'h0000_0001);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (enable_r && arm_r) begin
					state_nxt = ST_COUNT; // RULE9
				end
			end
			ST_COUNT: begin
				if (!enable_r || !arm_r) begin
					state_nxt = ST_IDLE; // RULE8
				end else if (expire && !strobe) begin
					state_nxt = ST_STAGE1; // RULE2
				end
			end
			ST_STAGE1: begin
				if (!enable_r || !arm_r) begin
					state_nxt = ST_IDLE; // RULE8
				end else if (strobe) begin
					state_nxt = ST_COUNT; // RULE14
				end else if (gapDone) begin
					state_nxt = ST_STAGE2; // RULE4
				end
			end
			ST_STAGE2: begin
				if (rst_r == HARD_RST_CYC[7:0] - 8'h01) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (anyRst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Elapsed units since the last strobe
	always_ff @(posedge mclk) begin
		if (anyRst || strobe || state_r != ST_COUNT) begin
			count_r <= 8'h00; // RULE5 RULE6 RULE9
		end else if (unitTick) begin
			count_r <= count_r + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (anyRst || state_r != ST_STAGE1) begin
			gap_r <= '0;
		end else begin
			gap_r <= gap_r + 32'h0000_0001; // RULE14
		end
	end

	// Hard reset pulse width counter, shared by watchdog and button
	always_ff @(posedge mclk) begin
		if (srst || powerOnRst) begin
			rst_r <= 8'h00;
		end else if (buttonRise || (state_r == ST_STAGE1 && state_nxt == ST_STAGE2)) begin
			rst_r <= HARD_RST_CYC[7:0]; // RULE4 RULE11
		end else if (rst_r != 8'h00) begin
			rst_r <= rst_r - 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (anyRst) begin
			hardReset            <= 1'b0;
			nonmaskableInterrupt <= 1'b0;
			processorSoftInit    <= 1'b0;
			statusLed            <= 1'b0;
		end else begin
			// Button held keeps the system in reset for its whole press
			hardReset            <= (rst_r != 8'h00) || buttonLvl; // RULE11
			nonmaskableInterrupt <= (state_nxt == ST_STAGE1) && !selInit_r; // RULE3
			processorSoftInit    <= (state_nxt == ST_STAGE1) && selInit_r; // RULE3
			statusLed            <= (state_nxt != ST_IDLE); // RULE13
		end
	end

	// Register read path, data one cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (anyRst) begin
			ioRdData <= DATA_ZERO;
		end else if (ioRd && hitStrobe) begin
			ioRdData <= term_r;
		end else if (ioRd && hitCtrl) begin
			ioRdData <= {cause_r, 1'b0, 2'b00, selInit_r, minutes_r, arm_r, enable_r}; // RULE7
		end else if (ioRd) begin
			ioRdData <= DATA_ZERO;
		end
	end
endmodule

// *** core/wdt_pkg.sv ***
// How it works
// RULE1: Timeout 1 to 255 seconds or minutes.
// RULE2: Missed strobe timeout enters first stage.
// RULE3: First stage raises NMI or init, selectable.
// RULE4: Second stage issues a hard reset.
// RULE5: Strobe port read restarts the count.
// RULE6: Strobe port write also restarts count.
// RULE7: Status shows watchdog caused last reset.
// RULE8: Disabled watchdog never takes any action. A second stage already begun still runs to its end.
// RULE9: Counting only while armed; strobes restart.
// RULE10: Software enables, programs, strobes in time.
// RULE11: Front reset button gives same hard reset.
// RULE12: Strobe port and control port adjacent.
// RULE13: Front LED shows watchdog status.
// RULE14: Stage gap is parameter; strobe cancels.
// RULE15: Reset cause survives hard reset.
package wdt_pkg;
	localparam int          IO_AW          = 16;
	localparam logic [15:0] ADDR_STROBE    = 16'h03F0;
	localparam logic [15:0] ADDR_CTRL      = 16'h03F1;

	// Control register fields
	localparam int          CTL_ENABLE     = 0;
	localparam int          CTL_ARM        = 1;
	localparam int          CTL_MINUTES    = 2;
	localparam int          CTL_SEL_INIT   = 3;
	localparam int          CTL_CLR_CAUSE  = 6;
	localparam int          CTL_CAUSE      = 7;
	localparam logic [7:0]  CTL_RESET      = 8'h00;
	localparam logic [7:0]  TERM_RESET     = 8'hFF;
	localparam logic [7:0]  TERM_ZERO      = 8'h00;
	localparam logic [7:0]  DATA_ZERO      = 8'h00;

	// Time base
	localparam longint      CLK_HZ         = 100_000_000;
	localparam longint      UNIT_S         = 1;
	localparam longint      SEC_CYCLES     = CLK_HZ * UNIT_S;
	localparam int          SEC_PER_MIN    = 60;
	localparam int          PRE_W          = 32;
	localparam logic [5:0]  MIN_LAST       = 6'h3B;
	localparam int          STAGE_GAP_S    = 1;
	localparam longint      GAP_CYCLES     = CLK_HZ * STAGE_GAP_S;
	localparam int          HARD_RST_NS    = 1000;
	localparam int          CLK_NS         = 10;
	localparam int          HARD_RST_CYC   = (HARD_RST_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_COUNT  = 2'b01,
		ST_STAGE1 = 2'b11,
		ST_STAGE2 = 2'b10
	} wdt_state_t;
endpackage

// *** core/wdt_sync.sv ***
`timescale 1ns/100ps
// Two-stage synchroniser plus rising-edge pulse for the front button
module wdt_sync (
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic pinIn,
	output logic      levelOut,
	output logic      risePulse
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pinIn;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign levelOut  = sync_r;
	assign risePulse = sync_r & ~last_r;
endmodule

// *** core/wdt_timebase.sv ***
`timescale 1ns/100ps
// Unit tick generator; restart realigns so a strobe counts from zero
module wdt_timebase #(
	parameter logic [31:0] SEC_CYC = 32'h05F5_E100
) (
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic restart,
	input  wire logic minutes,
	output logic      unitTick
);
	import wdt_pkg::*;

	logic [PRE_W-1:0] pre_r;
	logic [5:0]       sec_r;
	logic             secTick;

	assign secTick = (pre_r == SEC_CYC - 32'h0000_0001);

	always_ff @(posedge mclk) begin
		if (srst || restart || secTick) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || restart) begin
			sec_r <= '0;
		end else if (secTick) begin
			sec_r <= (sec_r == MIN_LAST) ? 6'h00 : sec_r + 6'h01;
		end
	end

	assign unitTick = minutes ? (secTick && sec_r == MIN_LAST) : secTick; // RULE1
endmodule

// *** sim/wdt_checker.sv ***
`timescale 1ns/100ps
module wdt_checker #(
	parameter logic [31:0] SEC_CYC = 32'h0000_000A,
	parameter logic [31:0] GAP_CYC = 32'h0000_0005
) (
	input wire logic                      mclk,
	input wire logic                      srst,
	input wire logic                      powerOnRst,
	input wire logic [wdt_pkg::IO_AW-1:0] ioAddr,
	input wire logic                      ioRd,
	input wire logic                      ioWr,
	input wire logic [7:0]                ioRdData,
	input wire logic                      nonmaskableInterrupt,
	input wire logic                      processorSoftInit,
	input wire logic                      hardReset,
	input wire logic                      statusLed
);
	import wdt_pkg::*;
	wire        st = nonmaskableInterrupt | processorSoftInit;
	wire        acc = ioRd | ioWr;
	wire        sa = acc && ioAddr == ADDR_STROBE;
	logic [7:0] hrCnt_r;
	// Saturates so a held button cannot wrap the width count
	always_ff @(posedge mclk) begin
		if (srst || powerOnRst || !hardReset)
			hrCnt_r <= 8'h00;
		else if (hrCnt_r != 8'hFF)
			hrCnt_r <= hrCnt_r + 8'h01;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst || powerOnRst);
	property p_excl; !(nonmaskableInterrupt && processorSoftInit); endproperty
	a_excl: assert property (p_excl) else $error("both stage lines");
	property p_led; st |-> statusLed; endproperty
	a_led: assert property (p_led) else $error("led off in stage");
	property p_entry; $rose(st) |-> $past(statusLed); endproperty
	a_entry: assert property (p_entry) else $error("stage from idle");
	property p_hold; $rose(st) && !acc ##1 (!acc)[*4] |-> st; endproperty
	a_hold: assert property (p_hold) else $error("stage too short");
	property p_hr; $fell(hardReset) |-> hrCnt_r >= 8'h64; endproperty
	a_hr: assert property (p_hr) else $error("reset pulse short");
	property p_cancel; st && sa |-> ##[1:2] !st; endproperty
	a_cancel: assert property (p_cancel) else $error("no cancel");
	property p_restart; sa && !st |=> (!st)[*8]; endproperty
	a_restart: assert property (p_restart) else $error("early expiry");
	property p_rd0; ioRd && ioAddr != ADDR_STROBE && ioAddr != ADDR_CTRL |=> ioRdData == 8'h00;
	endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read");
endmodule
bind wdt_top wdt_checker #(.SEC_CYC(SEC_CYC), .GAP_CYC(GAP_CYC)) wdtChk (.mclk, .srst,
	.powerOnRst, .ioAddr, .ioRd, .ioWr, .ioRdData, .nonmaskableInterrupt, .processorSoftInit,
	.hardReset, .statusLed);

// *** sim/wdt_host.sv ***
`timescale 1ns/100ps
module wdt_host (
	input wire logic                 mclk,
	output logic [wdt_pkg::IO_AW-1:0] ioAddr,
	output logic                     ioRd,
	output logic                     ioWr,
	output logic [7:0]               ioWrData,
	input wire logic [7:0]           ioRdData
);
	import wdt_pkg::*;
	initial begin
		ioAddr = 16'h0000;
		ioRd = 1'b0;
		ioWr = 1'b0;
		ioWrData = 8'h00;
	end
	// Released lines carry inverted values so stale data is never mistaken
	task automatic wr(input logic [15:0] a, input logic [7:0] dat);
		@(posedge mclk) #1;
		ioAddr = a;
		ioWrData = dat;
		ioWr = 1'b1;
		@(posedge mclk) #1;
		ioWr = 1'b0;
		ioWrData = ~dat;
		ioAddr = ~a;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] dat);
		@(posedge mclk) #1;
		ioAddr = a;
		ioRd = 1'b1;
		@(posedge mclk) #1;
		ioRd = 1'b0;
		ioAddr = ~a;
		dat = ioRdData;
	endtask
	task automatic kick(input logic useWr, input logic [7:0] dat);
		logic [7:0] q;
		if (useWr)
			wr(ADDR_STROBE, dat);
		else
			rd(ADDR_STROBE, q);
	endtask
endmodule

// *** sim/wdt_top_test.sv ***
`timescale 1ns/100ps
module wdt_top_test;
	import wdt_pkg::*;
	localparam logic [31:0] SEC = 32'h0000_000A;
	localparam logic [31:0] GAP = 32'h0000_0005;
	logic             mclk, srst, powerOnRst, frontResetButton, ioRd, ioWr;
	logic [IO_AW-1:0] ioAddr;
	logic [7:0]       ioWrData, ioRdData, d, t, ctl;
	logic             nonmaskableInterrupt, processorSoftInit, hardReset, statusLed;
	logic [1:0]       seen;
	logic [15:0]      rnd;
	int               errorCnt, samplesChecked, n, per;
	wire  [1:0]       ev = {hardReset, nonmaskableInterrupt | processorSoftInit};
	wdt_top #(.SEC_CYC(SEC), .GAP_CYC(GAP)) dut (
		.mclk, .srst, .powerOnRst, .ioAddr, .ioRd, .ioWr, .ioWrData, .ioRdData,
		.frontResetButton, .nonmaskableInterrupt, .processorSoftInit, .hardReset, .statusLed
	);
	wdt_host h (.mclk, .ioAddr, .ioRd, .ioWr, .ioWrData, .ioRdData);
	always @(posedge mclk)
		seen <= seen | ev;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [7:0] seenV, input logic [7:0] expV);
		samplesChecked++;
		if (seenV !== expV) begin
			errorCnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seenV, expV);
		end
	endtask
	task automatic finalReport;
		$display("compares %0d mismatches %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic waitEv(input int i, input int lim, output int c);
		c = 0;
		while (ev[i] !== 1'b1) begin
			@(posedge mclk) #1;
			c++;
			if (c > lim) begin
				chk(8'h00, 8'h01);
				finalReport;
			end
		end
	endtask
	task automatic quiet(input int c, input logic [1:0] mask);
		seen = 2'b00;
		repeat (c) @(posedge mclk);
		#1 chk({6'h00, seen & mask}, 8'h00);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		{srst, powerOnRst, frontResetButton, seen} = 5'h18;
		rnd = 16'h51DA;
		errorCnt = 0;
		samplesChecked = 0;
		repeat (4) @(posedge mclk);
		#1 {srst, powerOnRst} = 2'b00;
		h.rd(ADDR_CTRL, d);
		chk(d, CTL_RESET);
		h.rd(ADDR_STROBE, d);
		chk(d, TERM_RESET);
		h.rd(ADDR_CTRL + 16'h0001, d);
		chk(d, DATA_ZERO);
		h.wr(ADDR_STROBE, 8'h01);
		h.wr(ADDR_STROBE, TERM_ZERO);
		h.rd(ADDR_STROBE, d);
		chk(d, 8'h01);
		for (int c = 1; c < 3; c++) begin
			h.wr(ADDR_CTRL, 8'(c));
			quiet(40, 2'b11);
			chk({7'h00, statusLed}, 8'h00);
		end
		$display("idle test done");
		for (int m = 0; m < 4; m++) begin
			rnd = lfsr(rnd);
			t = m[1] ? 8'h01 : 8'(rnd[1:0] % 3) + 8'h01;
			per = int'(t) * int'(SEC) * (m[1] ? SEC_PER_MIN : 1);
			h.wr(ADDR_CTRL, CTL_RESET);
			h.wr(ADDR_STROBE, t);
			h.rd(ADDR_STROBE, d);
			chk(d, t);
			ctl = {4'h0, m[0], m[1], 2'b11};
			h.wr(ADDR_CTRL, ctl);
			seen = 2'b00;
			repeat (4) begin
				repeat (per - 6) @(posedge mclk);
				h.kick(rnd[m], rnd[15:8]);
			end
			chk({6'h00, seen}, 8'h00);
			// Armed strobe writes must not have reloaded the period
			h.rd(ADDR_STROBE, d);
			chk(d, t);
			chk({7'h00, statusLed}, 8'h01);
			waitEv(0, per + 4, n);
			chk(8'(n >= per - 3 && n <= per + 2), 8'h01);
			chk({6'h00, nonmaskableInterrupt, processorSoftInit}, m[0] ? 8'h01 : 8'h02);
			if (m == 2) begin
				h.kick(1'b0, 8'h00);
				h.wr(ADDR_CTRL, CTL_RESET);
				quiet(GAP + 110, 2'b10);
			end else begin
				waitEv(1, GAP + 4, n);
				h.rd(ADDR_CTRL, d);
				chk(d, ctl ^ 8'h82);
				repeat (110) @(posedge mclk);
				#1 srst = 1'b1;
				repeat (2) @(posedge mclk);
				#1 srst = 1'b0;
				h.rd(ADDR_CTRL, d);
				chk(d, 8'h80);
				h.wr(ADDR_CTRL, 8'h40);
				h.rd(ADDR_CTRL, d);
				chk(d, CTL_RESET);
			end
			$display("mode %0d done", m);
		end
		frontResetButton = 1'b1;
		repeat (3) @(posedge mclk);
		#1 frontResetButton = 1'b0;
		waitEv(1, 6, n);
		n = 0;
		while (hardReset === 1'b1 && n < 200) begin
			@(posedge mclk) #1;
			n++;
		end
		chk(8'(n >= 95 && n < 200), 8'h01);
		$display("button done");
		finalReport;
	end
endmodule
